// ### mdsm_pkg.sv
/*
  Constants for the MDIO station manager: frame layout, opcodes,
  field positions and divider limits.
  Assumes a 100 MHz management clock and clause 22 framing.
*/
`default_nettype none
package mdsm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MDC_MAX_HZ = 2_500_000;
  // Smallest divider that keeps mdc at or below the bus limit
  localparam int unsigned MDC_MIN_DIV = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ) - 1;
  localparam logic [4:0] DIV_OFF = 5'h00;
  localparam logic [4:0] DIV_RESET = 5'h00;
  localparam logic [31:0] PRE_ONES = 32'hFFFF_FFFF;
  localparam logic [1:0] START_BITS = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_READ = 2'h3;
  localparam logic [5:0] OP_POS = 6'h22;
  localparam logic [5:0] TA_POS = 6'h2E;
  localparam logic [5:0] DATA_POS = 6'h30;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam int unsigned PHY_HI = 9;
  localparam int unsigned PHY_LO = 5;
  localparam int unsigned REG_HI = 4;
  localparam int unsigned REG_LO = 0;
  typedef enum logic {ST_IDLE, ST_SHIFT} mdsm_state_t;
endpackage
`default_nettype wire

// ### mdsm_mdc_if.sv
/*
  Carrier between the frame engine and the mdc generator.
  Assumes both ends sit on the same management clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mdsm_mdc_if;
  logic [4:0] divider;
  logic run;
  logic mdc;
  logic rise;
  modport gen (input divider, input run, output mdc, output rise);
  modport core (output divider, output run, input mdc, input rise);
endinterface
`default_nettype wire

// ### mdsm_mdc_gen.sv
/*
  mdc generator: divides clk by 2*(1+divider), low while stopped,
  and flags each rising edge of mdc with a one-cycle pulse.
  Assumes divider is non-zero whenever run is high.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsm_mdc_gen
  import mdsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  mdsm_mdc_if.gen tick
);
  logic [4:0] half_cnt_q;
  logic mdc_q;
  logic rise_q;

  // Half period of divider+1 clocks
  always_ff @(posedge clk) begin
    if (rst || !tick.run) begin
      half_cnt_q <= 5'h00;
      mdc_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (half_cnt_q == tick.divider) begin
      half_cnt_q <= 5'h00;
      mdc_q <= !mdc_q;
      rise_q <= !mdc_q;
    end else begin
      half_cnt_q <= 5'(half_cnt_q + 5'h01);
      rise_q <= 1'b0;
    end
  end

  assign tick.mdc = mdc_q;
  assign tick.rise = rise_q;
endmodule // mdsm_mdc_gen
`default_nettype wire

// ### mdsm_top.sv
/*
  MDIO station manager: runs clause 22 read and write frames on a
  two-wire mdc/mdio link on request from the host management port.
  Assumes host inputs are on clk; mdio_in comes from the pad.
*/
// Functional notes
// - Opcode 01 sends a write frame carrying sixteen data bits.
// - Opcode 10 sends a read frame; PHY returns sixteen data bits.
// - Block makes mdc itself from clk using the five-bit divider.
// - mdc frequency is clk frequency over 2*(1+divider).
// - Divider resets to zero; zero keeps the interface disabled. Here mdc_divider is a host input that rst does not clear.
// - Requests reach MDIO only while mdio_path_select is high.
// - Host opcode goes unchanged into the frame opcode field.
// - PHY address is address bits 9:5, register address bits 4:0.
// - Write word bits 15:0 form the write data field.
// - Read data field lands on read word bits 15:0.
// - Idle flag high whenever a new transaction can be taken.
// - A request pulse starts the frame on the bus.
// - Requests during a transaction are ignored harmlessly.
// - Idle flag low while the frame is shifting.
// - Idle rises at frame end with read data already valid.
// - Link is mdc plus one shared bidirectional mdio line.
`timescale 1ns/1ps
`default_nettype none
module mdsm_top
  import mdsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mdio_path_select,
  input wire logic mgmt_request_pulse,
  input wire logic [1:0] host_operation_code,
  input wire logic [9:0] mgmt_target_address,
  input wire logic [15:0] mgmt_write_word,
  input wire logic [4:0] mdc_divider,
  input wire logic mdio_enable,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe_n,
  output logic serial_mgmt_idle,
  output logic [15:0] mgmt_read_word
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic released(input logic [1:0] op, input logic [5:0] idx);
    released = (op == OP_READ) && (idx >= TA_POS);
  endfunction

  function automatic logic [63:0] build_frame(input logic [1:0] op,
                                              input logic [9:0] addr,
                                              input logic [15:0] data);
    build_frame = {PRE_ONES, START_BITS, op, addr[PHY_HI:PHY_LO], addr[REG_HI:REG_LO],
                   (op == OP_READ) ? TA_READ : TA_WRITE, data};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // mdc generation

  mdsm_mdc_if tick ();
  logic enabled;

  assign enabled = mdio_enable && (mdc_divider != DIV_OFF);
  assign tick.divider = mdc_divider;
  assign tick.run = enabled;

  mdsm_mdc_gen u_mdc_gen (
    .clk (clk),
    .rst (rst),
    .tick (tick)
  );

  assign mdc = tick.mdc;

  ////////////////////////////////////////////////////////////////////
  // Pad input synchroniser

  logic mdio_meta_q;
  logic mdio_sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      mdio_meta_q <= 1'b1;
      mdio_sync_q <= 1'b1;
    end else begin
      mdio_meta_q <= mdio_in;
      mdio_sync_q <= mdio_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame engine

  mdsm_state_t state_q;
  logic [5:0] bit_cnt_q;
  logic [63:0] frame_q;
  logic [1:0] op_q;
  logic mdio_out_q;
  logic mdio_oe_n_q;
  logic accept;
  logic last_rise;

  assign accept = enabled && (state_q == ST_IDLE) && mgmt_request_pulse
                  && mdio_path_select;
  assign last_rise = (state_q == ST_SHIFT) && tick.rise && (bit_cnt_q == LAST_BIT);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 6'h00;
      frame_q <= 64'h0;
      op_q <= 2'h0;
      mdio_out_q <= 1'b1;
      mdio_oe_n_q <= 1'b1;
    end else if (!enabled) begin
      state_q <= ST_IDLE;
      mdio_out_q <= 1'b1;
      mdio_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_SHIFT;
            bit_cnt_q <= 6'h00;
            // Write word captured with the request
            frame_q <= build_frame(host_operation_code, mgmt_target_address,
                                   mgmt_write_word);
            op_q <= host_operation_code;
            mdio_out_q <= PRE_ONES[31];
            mdio_oe_n_q <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (tick.rise) begin
            if (bit_cnt_q == LAST_BIT) begin
              state_q <= ST_IDLE;
              mdio_out_q <= 1'b1;
              mdio_oe_n_q <= 1'b1;
            end else begin
              bit_cnt_q <= 6'(bit_cnt_q + 6'h01);
              frame_q <= {frame_q[62:0], 1'b0};
              mdio_out_q <= frame_q[62];
              mdio_oe_n_q <= released(op_q, 6'(bit_cnt_q + 6'h01));
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data capture

  logic [15:0] shift_in_q;
  logic [15:0] read_word_q;
  logic [15:0] shift_in_d;

  assign shift_in_d = {shift_in_q[14:0], mdio_sync_q};

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_in_q <= 16'h0000;
      read_word_q <= 16'h0000;
    end else if ((state_q == ST_SHIFT) && tick.rise && (op_q == OP_READ)
                 && (bit_cnt_q >= DATA_POS)) begin
      shift_in_q <= shift_in_d;
      if (bit_cnt_q == LAST_BIT) begin
        read_word_q <= shift_in_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Ready flag

  logic idle_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= enabled && !accept
                && ((state_q == ST_IDLE) || last_rise);
    end
  end

  assign mdio_out = mdio_out_q;
  assign mdio_oe_n = mdio_oe_n_q;
  assign serial_mgmt_idle = idle_q;
  assign mgmt_read_word = read_word_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [6:0] since_rise_q;
  logic [4:0] div_at_rise_q;
  logic period_ok_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      since_rise_q <= 7'h00;
      div_at_rise_q <= 5'h00;
      period_ok_q <= 1'b0;
    end else if (!enabled) begin
      period_ok_q <= 1'b0;
    end else if (tick.rise) begin
      since_rise_q <= 7'h01;
      div_at_rise_q <= mdc_divider;
      period_ok_q <= 1'b1;
    end else if (since_rise_q != 7'h7F) begin
      since_rise_q <= 7'(since_rise_q + 7'h01);
    end
  end

  sequence s_accept;
    accept;
  endsequence

  sequence s_last;
    last_rise;
  endsequence

  AST_MDC_PERIOD: assert property (tick.rise && period_ok_q && (mdc_divider == div_at_rise_q)
      |-> since_rise_q == ({1'b0, mdc_divider, 1'b0} + 7'h02))
    else $error("mdc period differs from 2*(1+divider)");
  AST_DIV_ZERO: assert property ((mdc_divider == DIV_OFF) |=> !idle_q && !tick.mdc)
    else $error("interface active with zero divider");
  AST_BUSY_LOW: assert property (s_accept |=> !idle_q [*8])
    else $error("idle flag high during a frame");
  AST_IGNORE_BUSY: assert property ((state_q == ST_SHIFT) && mgmt_request_pulse
      |=> $stable(op_q) && ((bit_cnt_q == $past(bit_cnt_q))
          || (bit_cnt_q == 6'($past(bit_cnt_q) + 6'h01)) || (state_q == ST_IDLE)))
    else $error("busy request disturbed the frame");
  AST_DONE_IDLE: assert property (s_last ##1 !mgmt_request_pulse |-> idle_q)
    else $error("idle flag not raised at frame end");
  AST_READ_DATA: assert property ((s_last and (op_q == OP_READ))
      |=> mgmt_read_word == $past(shift_in_d))
    else $error("read word not loaded at frame end");
  AST_PREAMBLE: assert property ((state_q == ST_SHIFT) && (bit_cnt_q < PRE_LEN)
      |-> mdio_out_q && !mdio_oe_n_q)
    else $error("preamble bit not driven one");
  AST_OPFIELD: assert property ((state_q == ST_SHIFT) && (bit_cnt_q == OP_POS)
      |-> mdio_out_q == op_q[1])
    else $error("opcode field mismatch");
  AST_RELEASE: assert property ((state_q == ST_SHIFT) && (op_q == OP_READ)
      && (bit_cnt_q >= TA_POS) |-> mdio_oe_n_q)
    else $error("mdio driven during read turnaround or data");
  AST_EDGE_CHANGE: assert property ((state_q == ST_SHIFT) && $changed(mdio_out_q)
      |-> $past(tick.rise) || $past(accept))
    else $error("mdio changed away from an mdc rise");
  AST_PATH_SEL: assert property (mgmt_request_pulse && !mdio_path_select
      && (state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("request taken without path select");
endmodule // mdsm_top
`default_nettype wire

// ### mdsm_phy_model.sv
/*
  PHY model on the mdio line: decodes frames, keeps a register file.
  Assumes mdc and the resolved mdio level are on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsm_phy_model
  import mdsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio,
  output logic phy_out,
  output logic phy_oe
);
  logic mdc_q, busy_q;
  logic [3:0] hist_q;
  logic [15:0] sh_q;
  logic [15:0] mem [0:1023];
  logic [1:0] f_op, f_ta;
  logic [9:0] f_addr;
  logic [15:0] f_data;
  int n_q, n_frames;
  always_ff @(posedge clk) begin
    mdc_q <= mdc;
    if (rst) begin
      busy_q <= 1'b0;
      hist_q <= 4'h0;
      phy_oe <= 1'b0;
      phy_out <= 1'b1;
      n_frames <= 0;
    end else if (mdc && !mdc_q) begin
      if (!busy_q) begin
        hist_q <= {hist_q[2:0], mdio};
        busy_q <= ({hist_q[2:0], mdio} == 4'hD);
        n_q <= 1;
      end else begin
        sh_q <= {sh_q[14:0], mdio};
        n_q <= n_q + 1;
        if (n_q == 12) begin
          f_op <= sh_q[10:9];
          f_addr <= {sh_q[8:0], mdio};
        end
        if (n_q == 14) f_ta <= {sh_q[0], mdio};
        if (n_q == 13 && f_op == OP_READ) begin
          phy_oe <= 1'b1;
          phy_out <= 1'b0;
        end
        if (n_q >= 14 && n_q <= 29 && f_op == OP_READ) phy_out <= mem[f_addr][29 - n_q];
        if (n_q == 30) begin
          busy_q <= 1'b0;
          hist_q <= 4'h0;
          phy_oe <= 1'b0;
          phy_out <= 1'b1;
          n_frames <= n_frames + 1;
          f_data <= {sh_q[14:0], mdio};
          if (f_op == OP_WRITE) mem[f_addr] <= {sh_q[14:0], mdio};
        end
      end
    end
  end
endmodule // mdsm_phy_model
`default_nettype wire

// ### mdio_station_manager_test.sv
/*
  Self-checking bench for the station manager against the PHY model.
  Assumes mdio has a pull-up when nobody drives it.
*/
`timescale 1ns/1ps
`default_nettype none
module mdio_station_manager_test;
  import mdsm_pkg::*;
  logic clk, rst, sel, req, en, phy_out, phy_oe;
  logic [1:0] op;
  logic [9:0] addr;
  logic [15:0] wdata;
  logic [4:0] div;
  wire logic mdc, mdio_out, mdio_oe_n, idle, mdio_line;
  wire logic [15:0] rdata;
  int n_errors, n_checks, cycles;
  assign mdio_line = !mdio_oe_n ? mdio_out : (phy_oe ? phy_out : 1'b1);
  mdsm_top dut_u (.clk(clk), .rst(rst), .mdio_path_select(sel), .mgmt_request_pulse(req),
    .host_operation_code(op), .mgmt_target_address(addr), .mgmt_write_word(wdata),
    .mdc_divider(div), .mdio_enable(en), .mdio_in(mdio_line), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .serial_mgmt_idle(idle),
    .mgmt_read_word(rdata));
  mdsm_phy_model phy_u (.clk(clk), .rst(rst), .mdc(mdc), .mdio(mdio_line),
    .phy_out(phy_out), .phy_oe(phy_oe));
  ////////////////////////////////////////////////////////////////////////
  task test_done;
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task err(input string msg);
    n_errors++;
    n_checks++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task ok;
    n_checks++;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_idle;
    for (int i = 0; i < 4000 && idle !== 1'b1; i++) step(1);
    if (idle !== 1'b1) err("idle never rose"); else ok();
  endtask
  task wait_rise;
    for (int i = 0; i < 200 && mdc !== 1'b0; i++) step(1);
    for (int i = 0; i < 200 && mdc !== 1'b1; i++) step(1);
  endtask
  // Request pulse; address and write word scrambled after the request cycle
  task xfer(input logic [1:0] o, input logic [9:0] a, input logic [15:0] d, input logic s);
    op = o;
    addr = a;
    wdata = d;
    sel = s;
    req = 1'b1;
    step(1);
    req = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_disabled;
    rst = 1'b0;
    step(10);
    if (idle !== 1'b0 || mdc !== 1'b0) err("enabled with zero divider"); else ok();
    xfer(OP_WRITE, 10'h123, 16'h1234, 1'b1);
    step(20);
    if (phy_u.n_frames != 0 || mdc !== 1'b0) err("frame while disabled"); else ok();
  endtask
  task t_mdc(input logic [4:0] d);
    int t0;
    div = d;
    step(4);
    wait_rise();
    t0 = cycles;
    wait_rise();
    if (cycles - t0 != 2 * (1 + int'(d))) err("mdc period"); else ok();
  endtask
  task t_write(input logic [9:0] a, input logic [15:0] d);
    int n0;
    n0 = phy_u.n_frames;
    xfer(OP_WRITE, a, d, 1'b1);
    step(1);
    if (idle !== 1'b0) err("idle during write"); else ok();
    step(100);
    xfer(OP_READ, ~a, 16'h0, 1'b1);
    wait_idle();
    if (phy_u.n_frames != n0 + 1) err("frame count"); else ok();
    if (phy_u.f_op !== OP_WRITE) err("write opcode"); else ok();
    if (phy_u.f_addr !== a) err("write address"); else ok();
    if (phy_u.f_data !== d) err("write data"); else ok();
    if (phy_u.f_ta !== TA_WRITE) err("write turnaround"); else ok();
  endtask
  task t_read(input logic [9:0] a, input logic [15:0] d);
    xfer(OP_READ, a, 16'h0, 1'b1);
    step(1);
    if (idle !== 1'b0) err("idle during read"); else ok();
    wait_idle();
    if (rdata !== d) err("read data"); else ok();
    if (phy_u.f_op !== OP_READ || phy_u.f_addr !== a) err("read header"); else ok();
  endtask
  task t_sel;
    int n0;
    n0 = phy_u.n_frames;
    xfer(OP_WRITE, 10'h2A5, 16'hFFFF, 1'b0);
    step(20);
    if (idle !== 1'b1 || phy_u.n_frames != n0) err("unselected request ran"); else ok();
  endtask
  task t_codes;
    static logic [1:0] codes [2] = '{2'h0, 2'h3};
    foreach (codes[i]) begin
      xfer(codes[i], 10'h155, 16'h0F0F, 1'b1);
      step(1);
      wait_idle();
      if (phy_u.f_op !== codes[i]) err("opcode field"); else ok();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 40000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    req = 1'b0;
    op = 2'h0;
    addr = 10'h000;
    wdata = 16'h0000;
    div = 5'h00;
    en = 1'b1;
    step(20);
    if (mdc !== 1'b0 || mdio_oe_n !== 1'b1 || rdata !== 16'h0000) err("reset"); else ok();
    t_disabled();
    div = 5'h03;
    wait_idle();
    t_mdc(5'h01);
    t_mdc(5'h1F);
    t_mdc(5'h03);
    t_mdc(5'(MDC_MIN_DIV));
    wait_idle();
    t_write(10'h2A5, 16'hA55A);
    t_write(10'h01F, 16'h8001);
    t_read(10'h2A5, 16'hA55A);
    t_read(10'h01F, 16'h8001);
    t_sel();
    t_codes();
    test_done();
  end
endmodule // mdio_station_manager_test
`default_nettype wire
